// file: design/dps_sram_port.sv
// pin level logic of a separate read/write port ddr burst sram
// How it works
// - write data is taken on both positive and negative clock rising edges
// - write select low on a positive clock edge starts a write
// - write select high: write data ignored, array untouched
// - four byte selects, sampled with their word, gate nine-bit lanes
// - a lane whose byte select is high keeps its stored value
// - shared address: read address on positive edge, write on negative
// - address ignored on the edge of a deselected port
// - read words launched on positive and negative clock rising edges
// - read select low on a positive edge starts a read there
// - on deselect, pending read finishes, then outputs float after next edge
// - every read returns exactly two sequential words
// - output valid marks driven words, aligned with the echo pair
// - termination range latched at start-up; high range is the default
// - accesses start only on positive clock rising edges
// - with pll bypass high the read latency is two clock cycles
// - echo pair runs free, following the positive and negative input clocks
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_sram_port import dps_pkg::*; #(
    parameter int AW    = `DPS_ADDR_W,
    parameter int DW    = `DPS_DATA_W,
    parameter int LANES = `DPS_LANES,
    parameter int DEPTH = `DPS_WBUF_DEPTH
) (
    // system clock, reset and enable
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // link clocks from the controller
    input  wire logic             k_clk,
    input  wire logic             k_clk_n,
    // command pins
    input  wire logic [AW-1:0]    addr,
    input  wire logic             write_port_select_n,
    input  wire logic             read_port_select_n,
    input  wire logic [LANES-1:0] byte_write_select_n,
    // write data
    input  wire logic [DW-1:0]    wdata,
    // static straps
    input  wire logic             pll_bypass_n,
    input  wire logic             termination_range_select,
    // read data and timing outputs
    output logic [DW-1:0]         rdata,
    output logic                  rdata_oe,
    output logic                  output_valid,
    output logic [1:0]            echo_timing_pair,
    // status
    output logic                  termination_range_high,
    output logic                  write_buffer_ready
);
    localparam int LW = DW / LANES;
    localparam int EW = AW + 2 * (DW + LANES);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic             k;
        logic             kn;
        logic             wsel_n;
        logic             rsel_n;
        logic             byp_n;
        logic             term;
        logic [AW-1:0]    addr;
        logic [DW-1:0]    d;
        logic [LANES-1:0] lane_n;
    } dps_pin_t;

    typedef struct packed {
        dps_pin_t         s1;
        dps_pin_t         s2;
        logic             k_prev;
        logic             kn_prev;
        dps_wr_state_t    wst;
        logic [DW-1:0]    wd0;
        logic [LANES-1:0] wb0_n;
        logic             p1_v;
        logic [AW-1:0]    p1_a;
        logic             p2_v;
        logic [AW-1:0]    p2_a;
        logic             sec_v;
        logic [AW-1:0]    sec_a;
        logic [DW-1:0]    rdata;
        logic             oe;
        logic             vld;
        logic [1:0]       echo;
        logic [1:0]       init_cnt;
        logic             term_high;
        logic             wbuf_rdy;
    } dps_st_t;

    dps_st_t        q;
    dps_st_t        d;
    dps_pin_t       pins;

    // the two halves of every burst live in separate arrays
    logic [DW-1:0]  bank0 [0:(1<<AW)-1];
    logic [DW-1:0]  bank1 [0:(1<<AW)-1];

    logic           k_rise;
    logic           kn_rise;
    logic           lat2;
    logic           launch_v;
    logic [AW-1:0]  launch_a;
    logic [AW-1:0]  pop_a;
    logic [DW-1:0]  pop_d0;
    logic [DW-1:0]  pop_d1;
    logic [LANES-1:0] pop_b0_n;
    logic [LANES-1:0] pop_b1_n;
    logic           pop_fire;

    dps_fifo_if #(.W(EW)) wb ();

    // ************************************************************
    // lane merge
    // ************************************************************
    function automatic logic [DW-1:0] lane_merge(
        input logic [DW-1:0]    old_w,
        input logic [DW-1:0]    new_w,
        input logic [LANES-1:0] sel_n
    );
        logic [DW-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!sel_n[i]) begin
                res[i*LW +: LW] = new_w[i*LW +: LW];
            end
        end
        return res;
    endfunction

    // ************************************************************
    // pin capture
    // ************************************************************
    always_comb begin
        pins.k      = k_clk;
        pins.kn     = k_clk_n;
        pins.wsel_n = write_port_select_n;
        pins.rsel_n = read_port_select_n;
        pins.byp_n  = pll_bypass_n;
        pins.term   = termination_range_select;
        pins.addr   = addr;
        pins.d      = wdata;
        pins.lane_n = byte_write_select_n;
    end

    // edges are found only on the second synchroniser stage
    assign k_rise   = q.s2.k & ~q.k_prev;
    assign kn_rise  = q.s2.kn & ~q.kn_prev;
    assign lat2     = q.s2.byp_n;
    assign launch_v = lat2 ? q.p2_v : q.p1_v;
    assign launch_a = lat2 ? q.p2_a : q.p1_a;

    // ************************************************************
    // write buffer
    // ************************************************************
    // a burst leaves for the buffer once its second word is in
    assign wb.push_valid = kn_rise && (q.wst == DPS_WR_ARMED);
    assign wb.push_data  = {q.s2.addr, q.s2.lane_n, q.s2.d, q.wb0_n, q.wd0};
    // the arrays serve reads on link edges, so draining waits then
    assign wb.pop_ready  = ~(k_rise | kn_rise);
    assign {pop_a, pop_b1_n, pop_d1, pop_b0_n, pop_d0} = wb.pop_data;
    assign pop_fire      = wb.pop_valid & wb.pop_ready & clk_en;

    dps_wbuf #(
        .W     (EW),
        .DEPTH (DEPTH)
    ) u_wbuf (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .fif     (wb)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d         = q;
        d.s1      = pins;
        d.s2      = q.s1;
        d.k_prev  = q.s2.k;
        d.kn_prev = q.s2.kn;
        d.echo    = {q.s2.kn, q.s2.k};
        d.wbuf_rdy = wb.push_ready;

        // strap latched once, after the synchroniser has filled
        if (q.init_cnt != `DPS_INIT_LAST) begin
            d.init_cnt = q.init_cnt + 2'h1;
            if (q.init_cnt == `DPS_INIT_SAMPLE) begin
                d.term_high = q.s2.term;
            end
        end

        if (k_rise) begin
            // launch the first word of the burst due on this edge
            if (launch_v) begin
                d.rdata = bank0[launch_a];
                d.oe    = 1'b1;
                d.vld   = 1'b1;
                d.sec_v = 1'b1;
                d.sec_a = launch_a;
            end else begin
                // nothing pending: outputs float after this edge
                d.oe    = 1'b0;
                d.vld   = 1'b0;
                d.sec_v = 1'b0;
            end
            // read pipeline advances one link cycle
            d.p2_v = q.p1_v;
            d.p2_a = q.p1_a;
            d.p1_v = ~q.s2.rsel_n;
            if (!q.s2.rsel_n) begin
                d.p1_a = q.s2.addr;
            end
            // write starts only here, never on the negative edge
            if (!q.s2.wsel_n) begin
                d.wst   = DPS_WR_ARMED;
                d.wd0   = q.s2.d;
                d.wb0_n = q.s2.lane_n;
            end else begin
                d.wst   = DPS_WR_IDLE;
            end
        end

        if (kn_rise) begin
            if (q.sec_v) begin
                d.rdata = bank1[q.sec_a];
                d.sec_v = 1'b0;
            end
            if (q.wst == DPS_WR_ARMED) begin
                d.wst = DPS_WR_IDLE;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q           <= '0;
            q.s1.wsel_n <= 1'b1;
            q.s1.rsel_n <= 1'b1;
            q.s2.wsel_n <= 1'b1;
            q.s2.rsel_n <= 1'b1;
            q.wst       <= DPS_WR_IDLE;
            q.wb0_n     <= '1;
            q.term_high <= `DPS_TERM_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ************************************************************
    // arrays
    // ************************************************************
    // no reset on the arrays; a burst writes both halves at once
    always_ff @(posedge mclk) begin
        if (pop_fire) begin
            bank0[pop_a] <= lane_merge(bank0[pop_a], pop_d0, pop_b0_n);
            bank1[pop_a] <= lane_merge(bank1[pop_a], pop_d1, pop_b1_n);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata                  = q.rdata;
    assign rdata_oe               = q.oe;
    assign output_valid           = q.vld;
    assign echo_timing_pair       = q.echo;
    assign termination_range_high = q.term_high;
    assign write_buffer_ready     = q.wbuf_rdy;
endmodule

// file: common/dps_map.svh
// constants for the dual port ddr sram pin interface
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

// ************************************************************
// array geometry
// ************************************************************
`define DPS_ADDR_W       20
`define DPS_DATA_W       36
`define DPS_LANES        4

// ************************************************************
// write buffer depth in entries, read latency in link clock cycles
// ************************************************************
`define DPS_WBUF_DEPTH   32
`define DPS_LAT_PLL_ON   2
`define DPS_LAT_PLL_OFF  1

// ************************************************************
// reset values
// ************************************************************
`define DPS_TERM_RST     1'b1
`define DPS_INIT_LAST    2'h3
`define DPS_INIT_SAMPLE  2'h2

`endif

// file: common/dps_pkg.sv
// types shared by the dual port ddr sram pin interface
package dps_pkg;

    // write burst tracker: first word taken, waiting for the second edge
    typedef enum logic [1:0] {
        DPS_WR_IDLE  = 2'b01,
        DPS_WR_ARMED = 2'b10
    } dps_wr_state_t;

endpackage

// file: common/dps_fifo_if.sv
// valid/ready carrier between the pin logic and the write buffer
`timescale 1ns/1ps
interface dps_fifo_if #(
    parameter int W = 8
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport store (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );

    modport user (
        output push_valid,
        input  push_ready,
        output push_data,
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface

// file: design/dps_wbuf.sv
// write burst buffer: parameterised fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_wbuf import dps_pkg::*; #(
    parameter int W     = 8,
    parameter int DEPTH = `DPS_WBUF_DEPTH
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    input  wire logic  clk_en,
    // buffer ports
    dps_fifo_if.store  fif
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0]   cnt;
    } dps_wbuf_st_t;

    dps_wbuf_st_t  q;
    dps_wbuf_st_t  d;
    logic [W-1:0]  mem [0:DEPTH-1];
    logic          push_fire;
    logic          pop_fire;

    assign fif.push_ready = (q.cnt != (PW+1)'(DEPTH));
    assign fif.pop_valid  = (q.cnt != '0);
    assign fif.pop_data   = mem[q.rp];
    assign push_fire      = fif.push_valid & fif.push_ready;
    assign pop_fire       = fif.pop_valid & fif.pop_ready;

    always_comb begin
        d = q;
        if (push_fire) begin
            d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end
        if (pop_fire) begin
            d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
        end
        d.cnt = q.cnt + (PW+1)'(push_fire) - (PW+1)'(pop_fire);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    always_ff @(posedge mclk) begin
        if (clk_en && push_fire) begin
            mem[q.wp] <= fif.push_data;
        end
    end
endmodule

// file: test/dps_sram_props.sv
// concurrent checks on the pin side of the sram port logic
`timescale 1ns/1ps
module dps_sram_props (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // link side inputs
    input wire logic       k_clk,
    input wire logic       k_clk_n,
    input wire logic       read_port_select_n,
    input wire logic       pll_bypass_n,
    // watched outputs
    input wire logic       rdata_oe,
    input wire logic       output_valid,
    input wire logic [1:0] echo_timing_pair,
    input wire logic       termination_range_high
);
    // ************************************************************
    // helper logic and assertions
    // ************************************************************
    logic [2:0] age_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    oe_valid_tied_a: assert property (rdata_oe == output_valid)
        else $error("read drive enable and valid disagree");
    valid_rise_k_a: assert property ($rose(output_valid) |-> k_clk)
        else $error("valid rose away from a positive clock edge");
    valid_fall_k_a: assert property ($fell(output_valid) |-> k_clk)
        else $error("valid fell away from a positive clock edge");
    valid_echo_a: assert property ($changed(output_valid)
        |-> $rose(echo_timing_pair[0]))
        else $error("valid moved apart from the positive echo");
    echo_pos_a: assert property ($stable(k_clk) [*6]
        |-> echo_timing_pair[0] == k_clk)
        else $error("positive echo does not follow the link clock");
    echo_neg_a: assert property ($stable(k_clk_n) [*6]
        |-> echo_timing_pair[1] == k_clk_n)
        else $error("negative echo does not follow the link clock");
    strap_held_a: assert property (age_q == 3'h7 |-> $stable(termination_range_high))
        else $error("termination range changed after start-up");
    read_lat2_a: assert property ($rose(k_clk) && !read_port_select_n
        && pll_bypass_n |-> ##[80:88] output_valid)
        else $error("read burst late with two cycle latency");
    read_lat1_a: assert property ($rose(k_clk) && !read_port_select_n
        && !pll_bypass_n |-> ##[40:48] output_valid)
        else $error("read burst late with one cycle latency");
endmodule
bind dps_sram_port dps_sram_props u_props (.mclk, .sys_rst, .k_clk, .k_clk_n,
    .read_port_select_n, .pll_bypass_n, .rdata_oe, .output_valid, .echo_timing_pair,
    .termination_range_high);

// file: test/dps_ctl_model.sv
// memory controller model: link clocks and command pins
`timescale 1ns/1ps
module dps_ctl_model #(
    parameter int AW = 8
) (
    // system clock
    input wire logic  mclk,
    // pins towards the sram
    output logic          k_clk,
    output logic          k_clk_n,
    output logic [AW-1:0] addr,
    output logic          write_port_select_n,
    output logic          read_port_select_n,
    output logic [3:0]    byte_write_select_n,
    output logic [35:0]   wdata
);
    // ************************************************************
    // free running link clock and one link cycle of commands
    // ************************************************************
    assign k_clk_n = ~k_clk;
    initial begin
        read_port_select_n  = 1'b1;
        write_port_select_n = 1'b1;
        addr                = {AW{1'b0}};
        wdata               = 36'h0;
        byte_write_select_n = 4'hF;
        k_clk               = 1'b0;
        // odd offset keeps the link clock out of phase with mclk
        #1.3;
        forever #80 k_clk = ~k_clk;
    end
    task automatic cycle(input logic rd_n, input logic wr_n, input logic [AW-1:0] ra,
        input logic [AW-1:0] wa, input logic [35:0] w0, input logic [3:0] b0,
        input logic [35:0] w1, input logic [3:0] b1);
        @(negedge k_clk);
        repeat (10) @(posedge mclk);
        read_port_select_n  <= rd_n;
        write_port_select_n <= wr_n;
        addr                <= ra;
        wdata               <= w0;
        byte_write_select_n <= b0;
        @(posedge k_clk);
        repeat (10) @(posedge mclk);
        read_port_select_n  <= 1'b1;
        write_port_select_n <= 1'b1;
        // an unused phase carries inverted junk, never the last value
        addr                <= wr_n ? ~ra : wa;
        wdata               <= wr_n ? ~w0 : w1;
        byte_write_select_n <= wr_n ? ~b0 : b1;
    endtask
endmodule

// file: test/tb_top.sv
// self-checking bench for the sram port logic
`timescale 1ns/1ps
module tb_top;
    // ************************************************************
    // signals, instances and shared tasks
    // ************************************************************
    localparam int AW = 8;
    localparam logic [35:0] D0 = 36'h912345678;
    localparam logic [35:0] D1 = 36'h6ABCDEF01;
    logic          mclk, sys_rst, pll_bypass_n, termination_range_select;
    logic          k_clk, k_clk_n, write_port_select_n, read_port_select_n;
    logic [AW-1:0] addr;
    logic [3:0]    byte_write_select_n;
    logic [35:0]   wdata, rdata;
    logic          rdata_oe, output_valid, termination_range_high, write_buffer_ready;
    logic [1:0]    echo_timing_pair;
    int            errors, tests_run;
    dps_ctl_model #(.AW(AW)) ctl (.mclk(mclk), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .addr(addr), .write_port_select_n(write_port_select_n),
        .read_port_select_n(read_port_select_n), .byte_write_select_n(byte_write_select_n),
        .wdata(wdata));
    dps_sram_port #(.AW(AW)) DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
        .k_clk(k_clk), .k_clk_n(k_clk_n), .addr(addr),
        .write_port_select_n(write_port_select_n), .read_port_select_n(read_port_select_n),
        .byte_write_select_n(byte_write_select_n), .wdata(wdata),
        .pll_bypass_n(pll_bypass_n), .termination_range_select(termination_range_select),
        .rdata(rdata), .rdata_oe(rdata_oe), .output_valid(output_valid),
        .echo_timing_pair(echo_timing_pair), .termination_range_high(termination_range_high),
        .write_buffer_ready(write_buffer_ready));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // waits on output_valid, or on rdata_oe when use_oe is set
    task automatic wait_lvl(input bit use_oe, input logic v, input int lim);
        logic s;
        s = use_oe ? rdata_oe : output_valid;
        for (int n = 0; n < lim && s !== v; n++) begin
            @(negedge mclk);
            s = use_oe ? rdata_oe : output_valid;
        end
        if (s !== v) begin
            check({35'h0, s}, {35'h0, v});
            final_report();
        end
    endtask
    // lanes whose select is high keep their old bits
    function automatic logic [35:0] keep(input logic [3:0] sel_n);
        for (int i = 0; i < 4; i++) keep[9*i +: 9] = {9{sel_n[i]}};
    endfunction
    task automatic cap(input logic [35:0] e0, input logic [35:0] e1);
        wait_lvl(1'b0, 1'b1, 200);
        check(rdata, e0);
        check({35'h0, rdata_oe}, 36'h1);
        repeat (25) @(negedge mclk);
        check(rdata, e1);
        check({35'h0, rdata_oe}, 36'h1);
        wait_lvl(1'b1, 1'b0, 24);
        check({35'h0, output_valid}, 36'h0);
    endtask
    // the burst shows about 73 mclk after the command returns with latency two, 33 with one
    task automatic rd(input logic [AW-1:0] a, input logic [35:0] e0, input logic [35:0] e1,
        input int early);
        ctl.cycle(1'b0, 1'b1, a, a, 36'h0, 4'hF, 36'h0, 4'hF);
        repeat (early) @(negedge mclk);
        check({35'h0, output_valid}, 36'h0);
        wait_lvl(1'b0, 1'b1, 20);
        cap(e0, e1);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [35:0] w0, input logic [3:0] b0,
        input logic [35:0] w1, input logic [3:0] b1);
        ctl.cycle(1'b1, 1'b0, ~a, a, w0, b0, w1, b1);
        // the write drains through the buffer before a read may see it
        repeat (80) @(negedge mclk);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_plain();
        wr(8'h12, D0, 4'h0, D1, 4'h0);
        rd(8'h12, D0, D1, 64);
    endtask
    task automatic t_lanes();
        wr(8'h12, 36'hFFFFFFFFF, 4'h5, 36'h0, 4'hA);
        rd(8'h12, (D0 & keep(4'h5)) | ~keep(4'h5), D1 & keep(4'hA), 64);
    endtask
    task automatic t_desel();
        ctl.cycle(1'b1, 1'b1, 8'h12, 8'h12, 36'h0, 4'h0, 36'h0, 4'h0);
        repeat (90) @(negedge mclk);
        check({35'h0, output_valid}, 36'h0);
        rd(8'h12, (D0 & keep(4'h5)) | ~keep(4'h5), D1 & keep(4'hA), 64);
    endtask
    task automatic t_both();
        ctl.cycle(1'b0, 1'b0, 8'h12, 8'h34, D1, 4'h0, D0, 4'h0);
        cap((D0 & keep(4'h5)) | ~keep(4'h5), D1 & keep(4'hA));
        repeat (80) @(negedge mclk);
        rd(8'h34, D1, D0, 64);
    endtask
    task automatic t_lat1();
        @(posedge mclk);
        pll_bypass_n <= 1'b0;
        repeat (80) @(negedge mclk);
        rd(8'h34, D1, D0, 24);
        @(posedge mclk);
        pll_bypass_n <= 1'b1;
        repeat (80) @(negedge mclk);
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        pll_bypass_n = 1'b1;
        termination_range_select = 1'b0;
        repeat (16) @(posedge mclk);
        check({35'h0, termination_range_high}, 36'h1);
        sys_rst <= 1'b0;
        repeat (10) @(negedge mclk);
        check({35'h0, termination_range_high}, 36'h0);
        check({35'h0, write_buffer_ready}, 36'h1);
        t_plain();
        t_lanes();
        t_desel();
        t_both();
        t_lat1();
        final_report();
    end
endmodule
